// ### rtl/spi_slave_pkg.sv
// register map, field layout and semaphore states of the pin-routed spi slave
package spi_slave_pkg;
  localparam logic [11:0] OFS_TAKE = 12'h024;
  localparam logic [11:0] OFS_GIVE = 12'h028;
  localparam logic [11:0] OFS_SUB_TAKE = 12'h0a4;
  localparam logic [11:0] OFS_SUB_GIVE = 12'h0a8;
  localparam logic [11:0] OFS_EV_DONE = 12'h104;
  localparam logic [11:0] OFS_EV_RXFULL = 12'h110;
  localparam logic [11:0] OFS_EV_GRANT = 12'h128;
  localparam logic [11:0] OFS_PUB_DONE = 12'h184;
  localparam logic [11:0] OFS_PUB_RXFULL = 12'h190;
  localparam logic [11:0] OFS_PUB_GRANT = 12'h1a8;
  localparam logic [11:0] OFS_LINKS = 12'h200;
  localparam logic [11:0] OFS_MASK_SET = 12'h304;
  localparam logic [11:0] OFS_MASK_CLR = 12'h308;
  localparam logic [11:0] OFS_SEM = 12'h400;
  localparam logic [11:0] OFS_ERRS = 12'h440;
  localparam logic [11:0] OFS_ONOFF = 12'h500;
  localparam logic [11:0] OFS_ROUTE_CLK = 12'h508;
  localparam logic [11:0] OFS_ROUTE_OUT = 12'h50c;
  localparam logic [11:0] OFS_ROUTE_IN = 12'h510;
  localparam logic [11:0] OFS_ROUTE_SEL = 12'h514;
  localparam logic [11:0] OFS_RX_BASE = 12'h534;
  localparam logic [11:0] OFS_RX_LIMIT = 12'h538;
  localparam logic [11:0] OFS_RX_LAST = 12'h53c;
  localparam logic [11:0] OFS_TX_BASE = 12'h544;
  localparam logic [11:0] OFS_TX_LIMIT = 12'h548;
  localparam logic [11:0] OFS_TX_LAST = 12'h54c;
  localparam logic [11:0] OFS_FORMAT = 12'h554;
  localparam logic [11:0] OFS_IGN_CHAR = 12'h55c;
  localparam logic [11:0] OFS_OVR_CHAR = 12'h5c0;
  localparam logic [11:0] OFS_TX_WIN = 12'h800;
  localparam logic [11:0] OFS_RX_WIN = 12'ha00;
  localparam int CONNECT_BIT = 31;
  localparam int HOOK_EN_BIT = 31;
  localparam int CPHA_BIT = 1;
  localparam int CPOL_BIT = 2;
  localparam int ERR_OVERREAD_BIT = 0;
  localparam int ERR_OVERFLOW_BIT = 1;
  localparam int CNT_W = 13;
  localparam logic [3:0] ONOFF_ON = 4'h2;
  localparam logic [31:0] ROUTE_RESET = 32'hffffffff;
  localparam logic [31:0] HOOK_MASK = 32'h8000000f;
  localparam logic [31:0] CNT_MASK = 32'h00001fff;
  localparam logic [31:0] CHAR_MASK = 32'h000000ff;
  localparam logic [31:0] FORMAT_MASK = 32'h00000006;
  localparam logic [31:0] ONOFF_MASK = 32'h0000000f;
  localparam logic [31:0] LINK_MASK = 32'h00000001;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  typedef enum logic [1:0] {
    SEM_FREE = 2'b00,
    SEM_CPU = 2'b01,
    SEM_SLAVE = 2'b10,
    SEM_CPU_WAIT = 2'b11
  } sem_e;
endpackage

// ### rtl/spi_slave_pins.sv
// pin-routed spi slave with semaphore-shared byte buffers and a wishbone register port
// Behaviour
// R1 - each slave signal uses the pad named by its own route register.
// R2 - a route marked disconnected ties its signal to no pad.
// R3 - routes apply only while enabled; otherwise pads follow gpio value and setup.
// R4 - software changes route registers only while the slave is off.
// R5 - software sets the four pads as gpio inputs before enabling.
// R6 - the slave-out pad floats whenever select is inactive.
// R7 - software lets only one peripheral drive any pad.
// R8 - writing 1 to give trigger frees the cpu hold; take trigger requests it.
// R9 - rx full flag becomes 1 when the rx limit is reached; else reads 0.
// R10 - take and give hooks fire their task from an enabled selected channel.
// R11 - done, rx full and granted events pulse their enabled selected channel.
// R12 - ignored transactions send the ignored fill character throughout.
// R13 - rx bytes last holds bytes stored in the latest granted transaction.
// R14 - tx bytes last holds bytes read in the latest granted transaction.
// R15 - bytes stored per granted transaction stop at the rx limit.
// R16 - bytes read per granted transaction stop at the tx limit.
// R17 - select falling tries to take the semaphore; failure ignores the transaction.
// R18 - a granted transaction ending releases the semaphore and raises done.
// R19 - link bit 1 makes done trigger the take task.
// R20 - on-off value 2 enables the slave, 0 disables it.
// R21 - software clears a flag with 0 before waiting for its next event.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_pins #(
  parameter int NPINS = 32,
  parameter int CHANS = 16,
  parameter int BUF_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [11:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] wrData,
  output logic ack,
  output logic [31:0] rdData,
  input wire logic [NPINS-1:0] padIn,
  output logic [NPINS-1:0] padOut,
  output logic [NPINS-1:0] padOe,
  input wire logic [NPINS-1:0] gpioOut,
  input wire logic [NPINS-1:0] gpioOe,
  input wire logic [CHANS-1:0] chanIn,
  output logic [CHANS-1:0] chanOut
);
  localparam int BW = $clog2(BUF_DEPTH);
  localparam int CW = spi_slave_pkg::CNT_W;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[8*b+:8] = wd[8*b+:8];
    end
    return res;
  endfunction

  function automatic logic pickPin(input logic [31:0] route, input logic [NPINS-1:0] pads, input logic idle);
    return route[spi_slave_pkg::CONNECT_BIT] ? idle : pads[route[4:0]];
  endfunction

  function automatic logic hookHit(input logic [31:0] hook, input logic [CHANS-1:0] chans);
    return hook[spi_slave_pkg::HOOK_EN_BIT] & chans[hook[3:0]];
  endfunction

  logic ack_r;
  logic [31:0] rdData_r, rdNxt;
  logic [NPINS-1:0] padOut_r, padOe_r, padS1_r, padS2_r;
  logic [CHANS-1:0] chanOut_r, chanNxt;
  logic [31:0] subTake_r, subGive_r, pubDone_r, pubRx_r, pubGrant_r, links_r, onOff_r;
  logic [31:0] routeClk_r, routeOut_r, routeIn_r, routeSel_r;
  logic [31:0] rxBase_r, rxLimit_r, txBase_r, txLimit_r, format_r, ignChar_r, ovrChar_r;
  logic [2:0] intMask_r;
  logic evDone_r, evRx_r, evGrant_r;
  logic [1:0] errs_r;
  spi_slave_pkg::sem_e sem_r, semNxt;
  logic [CW-1:0] rxLast_r, txLast_r, rxCnt_r, txCnt_r, txCntUse;
  logic [7:0] txBuf_r [BUF_DEPTH];
  logic [7:0] rxBuf_r [BUF_DEPTH];
  logic csnQ_r, sckQ_r, act_r, granted_r, first_r;
  logic [2:0] bitCnt_r;
  logic [6:0] rxSh_r;
  logic [7:0] txSh_r, txByte;
  logic en, cpol, cpha, csnNow, sckNow, mosiNow, csnFall, csnRise, lead, trail, sampleE, shiftE;
  logic wbReq, wbWr, takeTrig, giveTrig, grantEnd, grantNow, grantEvt, byteDone, rxStore, rxFullNow;
  logic overflowNow, loadNext, txLoad, txGrant, txFromBuf, overreadNow;
  logic [BW-1:0] winIdx;
  logic txWinHit, rxWinHit;

  assign ack = ack_r;
  assign rdData = rdData_r;
  assign padOut = padOut_r;
  assign padOe = padOe_r;
  assign chanOut = chanOut_r;

  assign en = onOff_r[3:0] == spi_slave_pkg::ONOFF_ON; // R20
  assign cpol = format_r[spi_slave_pkg::CPOL_BIT];
  assign cpha = format_r[spi_slave_pkg::CPHA_BIT];
  // disconnected inputs idle in their inactive level
  assign csnNow = pickPin(routeSel_r, padS2_r, 1'b1); // R1 R2
  assign sckNow = pickPin(routeClk_r, padS2_r, cpol); // R1 R2
  assign mosiNow = pickPin(routeIn_r, padS2_r, 1'b0); // R1 R2
  assign csnFall = en & csnQ_r & ~csnNow & ~act_r;
  assign csnRise = act_r & csnNow;
  assign lead = cpol ? (sckQ_r & ~sckNow) : (~sckQ_r & sckNow);
  assign trail = cpol ? (~sckQ_r & sckNow) : (sckQ_r & ~sckNow);
  assign sampleE = act_r & ~csnNow & (cpha ? trail : lead);
  assign shiftE = act_r & ~csnNow & (cpha ? lead : trail);

  assign wbReq = ce & cyc & stb & ~ack_r;
  assign wbWr = wbReq & we;
  assign winIdx = adr[BW+1:2];
  assign txWinHit = adr[11:BW+2] == spi_slave_pkg::OFS_TX_WIN[11:BW+2];
  assign rxWinHit = adr[11:BW+2] == spi_slave_pkg::OFS_RX_WIN[11:BW+2];
  assign takeTrig = (wbWr & adr == spi_slave_pkg::OFS_TAKE & sel[0] & wrData[0]) | hookHit(subTake_r, chanIn); // R8 R10
  assign giveTrig = (wbWr & adr == spi_slave_pkg::OFS_GIVE & sel[0] & wrData[0]) | hookHit(subGive_r, chanIn); // R8 R10
  assign grantEnd = csnRise & granted_r;

  assign byteDone = sampleE & bitCnt_r == spi_slave_pkg::BYTE_LAST;
  assign rxStore = byteDone & granted_r & (rxCnt_r < rxLimit_r[CW-1:0]); // R15
  assign rxFullNow = rxStore & (rxCnt_r + 13'h1 == rxLimit_r[CW-1:0]); // R9
  assign overflowNow = byteDone & granted_r & ~rxStore;

  // next byte is fetched on the shift edge after the last bit of the previous one
  assign loadNext = shiftE & ~(cpha & first_r) & bitCnt_r == 3'h0;
  assign txLoad = csnFall | loadNext;
  assign txGrant = csnFall ? grantNow : granted_r;
  assign txCntUse = csnFall ? '0 : txCnt_r;
  assign txFromBuf = txLoad & txGrant & (txCntUse < txLimit_r[CW-1:0]); // R16
  assign overreadNow = txLoad & txGrant & ~txFromBuf;
  always_comb
  begin
    if (!txGrant)
      txByte = ignChar_r[7:0]; // R12
    else if (txFromBuf)
      txByte = txBuf_r[txBase_r[BW-1:0] + txCntUse[BW-1:0]];
    else
      txByte = ovrChar_r[7:0];
  end

  // semaphore: a cpu take in the same cycle as select falling wins the race
  always_comb
  begin
    semNxt = sem_r;
    grantNow = 1'b0;
    grantEvt = 1'b0;
    if (!en)
      semNxt = spi_slave_pkg::SEM_CPU;
    else if (grantEnd)
    begin
      if (sem_r == spi_slave_pkg::SEM_CPU_WAIT || links_r[0] || takeTrig) // R19
      begin
        semNxt = spi_slave_pkg::SEM_CPU;
        grantEvt = 1'b1;
      end
      else
        semNxt = spi_slave_pkg::SEM_FREE; // R18
    end
    else if (takeTrig) // R8
    begin
      unique case (sem_r)
        spi_slave_pkg::SEM_FREE, spi_slave_pkg::SEM_CPU:
        begin
          semNxt = spi_slave_pkg::SEM_CPU;
          grantEvt = 1'b1;
        end
        spi_slave_pkg::SEM_SLAVE: semNxt = spi_slave_pkg::SEM_CPU_WAIT;
        spi_slave_pkg::SEM_CPU_WAIT: semNxt = sem_r;
      endcase
    end
    else if (csnFall && sem_r == spi_slave_pkg::SEM_FREE) // R17
    begin
      semNxt = spi_slave_pkg::SEM_SLAVE;
      grantNow = 1'b1;
    end
    else if (giveTrig && sem_r == spi_slave_pkg::SEM_CPU) // R8
      semNxt = spi_slave_pkg::SEM_FREE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sem_r <= spi_slave_pkg::SEM_CPU;
    else if (ce)
      sem_r <= semNxt;
  end

  // pad inputs cross into clk_sys through two flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      padS1_r <= '0;
      padS2_r <= '0;
      csnQ_r <= 1'b1;
      sckQ_r <= 1'b0;
    end
    else if (ce)
    begin
      padS1_r <= padIn;
      padS2_r <= padS1_r;
      csnQ_r <= csnNow;
      sckQ_r <= sckNow;
    end
  end

  // bit engine, msb first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      act_r <= 1'b0;
      granted_r <= 1'b0;
      first_r <= 1'b0;
      bitCnt_r <= '0;
      rxSh_r <= '0;
      txSh_r <= '0;
      rxCnt_r <= '0;
      txCnt_r <= '0;
      rxLast_r <= '0;
      txLast_r <= '0;
    end
    else if (ce)
    begin
      if (csnFall)
      begin
        act_r <= 1'b1;
        granted_r <= grantNow; // R17
        first_r <= 1'b1;
        bitCnt_r <= '0;
        rxCnt_r <= '0;
      end
      else if (!en || csnRise)
      begin
        act_r <= 1'b0;
        granted_r <= 1'b0;
      end
      if (grantEnd)
      begin
        rxLast_r <= rxCnt_r; // R13
        txLast_r <= txCnt_r; // R14
      end
      if (sampleE)
      begin
        rxSh_r <= {rxSh_r[5:0], mosiNow};
        bitCnt_r <= bitCnt_r + 3'h1;
      end
      if (rxStore)
        rxCnt_r <= rxCnt_r + 13'h1; // R15
      if (txLoad)
      begin
        txSh_r <= txByte; // R12
        txCnt_r <= txFromBuf ? txCntUse + 13'h1 : txCntUse; // R16
      end
      else if (shiftE)
      begin
        if (cpha && first_r)
          first_r <= 1'b0;
        else
          txSh_r <= {txSh_r[6:0], 1'b0};
      end
    end
  end

  // incoming data of an ignored transaction never reaches the buffer
  always_ff @(posedge clk_sys)
  begin
    if (ce && rxStore)
      rxBuf_r[rxBase_r[BW-1:0] + rxCnt_r[BW-1:0]] <= {rxSh_r, mosiNow};
    if (ce && wbWr && txWinHit)
      txBuf_r[winIdx] <= wrData[7:0];
  end

  // pads: gpio settings unless the slave is on and the route is connected
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      padOut_r <= '0;
      padOe_r <= '0;
    end
    else if (ce)
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        if (en && !routeOut_r[spi_slave_pkg::CONNECT_BIT] && routeOut_r[4:0] == 5'(i)) // R1 R2 R3
        begin
          padOut_r[i] <= txSh_r[7];
          padOe_r[i] <= ~csnNow; // R6
        end
        else
        begin
          padOut_r[i] <= gpioOut[i]; // R3
          padOe_r[i] <= gpioOe[i];
        end
      end
    end
  end

  // flags and errors: a hardware set wins over a software clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      evDone_r <= 1'b0;
      evRx_r <= 1'b0;
      evGrant_r <= 1'b0;
      errs_r <= '0;
    end
    else if (ce)
    begin
      evDone_r <= grantEnd | ((wbWr && adr == spi_slave_pkg::OFS_EV_DONE) ? wrData[0] : evDone_r); // R18
      evRx_r <= rxFullNow | ((wbWr && adr == spi_slave_pkg::OFS_EV_RXFULL) ? wrData[0] : evRx_r); // R9
      evGrant_r <= grantEvt | ((wbWr && adr == spi_slave_pkg::OFS_EV_GRANT) ? wrData[0] : evGrant_r);
      errs_r[spi_slave_pkg::ERR_OVERREAD_BIT] <= overreadNow | (errs_r[spi_slave_pkg::ERR_OVERREAD_BIT]
        & ~(wbWr && adr == spi_slave_pkg::OFS_ERRS && wrData[spi_slave_pkg::ERR_OVERREAD_BIT]));
      errs_r[spi_slave_pkg::ERR_OVERFLOW_BIT] <= overflowNow | (errs_r[spi_slave_pkg::ERR_OVERFLOW_BIT]
        & ~(wbWr && adr == spi_slave_pkg::OFS_ERRS && wrData[spi_slave_pkg::ERR_OVERFLOW_BIT]));
    end
  end

  always_comb
  begin
    chanNxt = '0;
    if (pubDone_r[spi_slave_pkg::HOOK_EN_BIT] && grantEnd)
      chanNxt[pubDone_r[3:0]] = 1'b1; // R11
    if (pubRx_r[spi_slave_pkg::HOOK_EN_BIT] && rxFullNow)
      chanNxt[pubRx_r[3:0]] = 1'b1; // R11
    if (pubGrant_r[spi_slave_pkg::HOOK_EN_BIT] && grantEvt)
      chanNxt[pubGrant_r[3:0]] = 1'b1; // R11
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      chanOut_r <= '0;
    else if (ce)
      chanOut_r <= chanNxt;
  end

  // configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      {subTake_r, subGive_r, pubDone_r, pubRx_r, pubGrant_r, links_r, onOff_r} <= '0;
      {routeClk_r, routeOut_r, routeIn_r, routeSel_r} <= {4{spi_slave_pkg::ROUTE_RESET}};
      {rxBase_r, rxLimit_r, txBase_r, txLimit_r, format_r, ignChar_r, ovrChar_r} <= '0;
      intMask_r <= '0;
    end
    else if (wbWr)
    begin
      unique case (adr)
        spi_slave_pkg::OFS_SUB_TAKE: subTake_r <= merge(subTake_r, wrData, sel) & spi_slave_pkg::HOOK_MASK;
        spi_slave_pkg::OFS_SUB_GIVE: subGive_r <= merge(subGive_r, wrData, sel) & spi_slave_pkg::HOOK_MASK;
        spi_slave_pkg::OFS_PUB_DONE: pubDone_r <= merge(pubDone_r, wrData, sel) & spi_slave_pkg::HOOK_MASK;
        spi_slave_pkg::OFS_PUB_RXFULL: pubRx_r <= merge(pubRx_r, wrData, sel) & spi_slave_pkg::HOOK_MASK;
        spi_slave_pkg::OFS_PUB_GRANT: pubGrant_r <= merge(pubGrant_r, wrData, sel) & spi_slave_pkg::HOOK_MASK;
        spi_slave_pkg::OFS_LINKS: links_r <= merge(links_r, wrData, sel) & spi_slave_pkg::LINK_MASK;
        spi_slave_pkg::OFS_MASK_SET: intMask_r <= intMask_r | wrData[2:0];
        spi_slave_pkg::OFS_MASK_CLR: intMask_r <= intMask_r & ~wrData[2:0];
        spi_slave_pkg::OFS_ONOFF: onOff_r <= merge(onOff_r, wrData, sel) & spi_slave_pkg::ONOFF_MASK; // R20
        spi_slave_pkg::OFS_ROUTE_CLK: routeClk_r <= merge(routeClk_r, wrData, sel);
        spi_slave_pkg::OFS_ROUTE_OUT: routeOut_r <= merge(routeOut_r, wrData, sel);
        spi_slave_pkg::OFS_ROUTE_IN: routeIn_r <= merge(routeIn_r, wrData, sel);
        spi_slave_pkg::OFS_ROUTE_SEL: routeSel_r <= merge(routeSel_r, wrData, sel);
        spi_slave_pkg::OFS_RX_BASE: rxBase_r <= merge(rxBase_r, wrData, sel);
        spi_slave_pkg::OFS_RX_LIMIT: rxLimit_r <= merge(rxLimit_r, wrData, sel) & spi_slave_pkg::CNT_MASK;
        spi_slave_pkg::OFS_TX_BASE: txBase_r <= merge(txBase_r, wrData, sel);
        spi_slave_pkg::OFS_TX_LIMIT: txLimit_r <= merge(txLimit_r, wrData, sel) & spi_slave_pkg::CNT_MASK;
        spi_slave_pkg::OFS_FORMAT: format_r <= merge(format_r, wrData, sel) & spi_slave_pkg::FORMAT_MASK;
        spi_slave_pkg::OFS_IGN_CHAR: ignChar_r <= merge(ignChar_r, wrData, sel) & spi_slave_pkg::CHAR_MASK;
        spi_slave_pkg::OFS_OVR_CHAR: ovrChar_r <= merge(ovrChar_r, wrData, sel) & spi_slave_pkg::CHAR_MASK;
        default: ;
      endcase
    end
  end

  // read mux; unmapped words read zero and are still acknowledged
  always_comb
  begin
    rdNxt = '0;
    if (txWinHit)
      rdNxt = {24'h0, txBuf_r[winIdx]};
    else if (rxWinHit)
      rdNxt = {24'h0, rxBuf_r[winIdx]};
    else
    begin
      case (adr)
        spi_slave_pkg::OFS_SUB_TAKE: rdNxt = subTake_r;
        spi_slave_pkg::OFS_SUB_GIVE: rdNxt = subGive_r;
        spi_slave_pkg::OFS_EV_DONE: rdNxt = {31'h0, evDone_r};
        spi_slave_pkg::OFS_EV_RXFULL: rdNxt = {31'h0, evRx_r}; // R9
        spi_slave_pkg::OFS_EV_GRANT: rdNxt = {31'h0, evGrant_r};
        spi_slave_pkg::OFS_PUB_DONE: rdNxt = pubDone_r;
        spi_slave_pkg::OFS_PUB_RXFULL: rdNxt = pubRx_r;
        spi_slave_pkg::OFS_PUB_GRANT: rdNxt = pubGrant_r;
        spi_slave_pkg::OFS_LINKS: rdNxt = links_r;
        spi_slave_pkg::OFS_MASK_SET, spi_slave_pkg::OFS_MASK_CLR: rdNxt = {29'h0, intMask_r};
        spi_slave_pkg::OFS_SEM: rdNxt = {30'h0, sem_r};
        spi_slave_pkg::OFS_ERRS: rdNxt = {30'h0, errs_r};
        spi_slave_pkg::OFS_ONOFF: rdNxt = onOff_r;
        spi_slave_pkg::OFS_ROUTE_CLK: rdNxt = routeClk_r;
        spi_slave_pkg::OFS_ROUTE_OUT: rdNxt = routeOut_r;
        spi_slave_pkg::OFS_ROUTE_IN: rdNxt = routeIn_r;
        spi_slave_pkg::OFS_ROUTE_SEL: rdNxt = routeSel_r;
        spi_slave_pkg::OFS_RX_BASE: rdNxt = rxBase_r;
        spi_slave_pkg::OFS_RX_LIMIT: rdNxt = rxLimit_r;
        spi_slave_pkg::OFS_RX_LAST: rdNxt = {19'h0, rxLast_r}; // R13
        spi_slave_pkg::OFS_TX_BASE: rdNxt = txBase_r;
        spi_slave_pkg::OFS_TX_LIMIT: rdNxt = txLimit_r;
        spi_slave_pkg::OFS_TX_LAST: rdNxt = {19'h0, txLast_r}; // R14
        spi_slave_pkg::OFS_FORMAT: rdNxt = format_r;
        spi_slave_pkg::OFS_IGN_CHAR: rdNxt = ignChar_r;
        spi_slave_pkg::OFS_OVR_CHAR: rdNxt = ovrChar_r;
        default: rdNxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rdData_r <= '0;
    end
    else if (ce)
    begin
      ack_r <= wbReq;
      if (wbReq)
        rdData_r <= rdNxt;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_ROUTE_DRIVES: assert property (ce && en && !routeOut_r[31] && !csnNow |=> padOe_r[routeOut_r[4:0]]) // R1
    else $error("slave-out pad not driven while selected");
  AST_DISC_NO_PAD: assert property (ce && en && routeOut_r[31] |=> padOe_r == $past(gpioOe)) // R2
    else $error("disconnected slave-out still reaches a pad");
  // the last reset edge still clears the pads, so it is kept out of the antecedent
  AST_OFF_GPIO: assert property (!rst && ce && !en |=> padOut_r == $past(gpioOut) && padOe_r == $past(gpioOe)) // R3
    else $error("pads not following gpio while disabled");
  AST_MISO_FLOAT: assert property (ce && en && !routeOut_r[31] && csnNow |=> !padOe_r[routeOut_r[4:0]]) // R6
    else $error("slave-out driven while not selected");
  AST_GIVE_FREES: assert property (ce && en && giveTrig && !takeTrig && !grantEnd
    && sem_r == spi_slave_pkg::SEM_CPU |=> sem_r == spi_slave_pkg::SEM_FREE) // R8
    else $error("give trigger did not free the semaphore");
  AST_TAKE_FLAG: assert property (ce && en && takeTrig && sem_r == spi_slave_pkg::SEM_CPU |=> evGrant_r) // R8
    else $error("take while held by cpu gave no granted flag");
  AST_RXFULL: assert property (ce && rxFullNow |=> evRx_r && rxCnt_r == $past(rxLimit_r[CW-1:0])) // R9
    else $error("rx full flag missing at the limit");
  AST_IGNORED_FILL: assert property (ce && txLoad && !txGrant |=> txSh_r == $past(ignChar_r[7:0])) // R12
    else $error("ignored transaction not sending fill character");
  AST_RX_LIMIT: assert property (granted_r |-> rxCnt_r <= rxLimit_r[CW-1:0]) // R15
    else $error("rx count beyond its limit");
  AST_TX_LIMIT: assert property (granted_r |-> txCnt_r <= txLimit_r[CW-1:0]) // R16
    else $error("tx count beyond its limit");
  AST_END_RELEASE: assert property (ce && en && grantEnd |=> evDone_r && sem_r != spi_slave_pkg::SEM_SLAVE
    && rxLast_r == $past(rxCnt_r)) // R18
    else $error("granted end did not release or flag done");
  AST_LINK_TAKE: assert property (ce && en && grantEnd && links_r[0] |=> sem_r == spi_slave_pkg::SEM_CPU
    ##0 evGrant_r) // R19
    else $error("done-to-take link did not hand over");
  AST_NO_GRANT: assert property (ce && csnFall && sem_r != spi_slave_pkg::SEM_FREE |=> !granted_r) // R17
    else $error("transaction granted without a free semaphore");
endmodule
`default_nettype wire

// ### test/spi_master_model.sv
// spi master model driving the slave's select, clock and data pads
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  output logic csnPad,
  output logic sckPad,
  output logic mosiPad,
  input wire logic misoPad
);
  initial
  begin
    csnPad = 1'b1;
    sckPad = 1'b0;
    mosiPad = 1'b0;
  end
  // clock parked at its idle level, select edge, then a settling gap; data line shows no stale value
  task automatic frame(input logic v, input logic ck);
    sckPad = ck;
    #200 csnPad = v;
    #200 mosiPad = ~mosiPad;
  endtask
  // mode 0 or mode 3, msb first; the clock stands still between frames
  task automatic xfer(input logic [7:0] tx, input logic m3, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (m3)
      begin
        #62 sckPad = 1'b0;
        mosiPad = tx[i];
        #63 sckPad = 1'b1;
        rx[i] = misoPad;
      end
      else
      begin
        mosiPad = tx[i];
        #62 sckPad = 1'b1;
        rx[i] = misoPad;
        #63 sckPad = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### test/spi_slave_pins_tb_top.sv
// self-checking bench for the pin-routed spi slave
`timescale 1ns/1ns
`default_nettype none
module spi_slave_pins_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, csnPad, sckPad, mosiPad;
  logic [11:0] adr = 12'h0;
  logic [31:0] wrData = 32'h0, rdData, rdq, padIn, padOut, padOe;
  logic [31:0] gpioOut = 32'h0, gpioOe = 32'h0, noise = 32'h0;
  logic [15:0] chanIn = 16'h0, chanSeen = 16'h0, chanOut;
  logic [7:0] b [3];
  logic [7:0] r [3];
  logic [7:0] txb, ign, ovr;
  int seed = 25295;
  int num_errors = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  // slave-out pad is pulled up while nobody drives it
  assign padIn = {noise[31:5], csnPad, mosiPad, padOe[2] ? padOut[2] : 1'b1, sckPad, noise[0]};
  spi_slave_pins dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(4'hf), .wrData(wrData), .ack(ack), .rdData(rdData), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .gpioOut(gpioOut), .gpioOe(gpioOe), .chanIn(chanIn), .chanOut(chanOut));
  // published pulses last one cycle, so they are gathered here
  always @(posedge clk_sys)
    if (!rst)
      chanSeen <= chanSeen | chanOut;
  spi_master_model mst_u (.csnPad(csnPad), .sckPad(sckPad), .mosiPad(mosiPad), .misoPad(padIn[2]));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wrData <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 99)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (ack !== 1'b1)
      num_errors++;
    rdq = rdData;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask
  task automatic shot(input int n, input logic m3);
    mst_u.frame(1'b0, m3);
    for (int i = 0; i < n; i++)
      mst_u.xfer(b[i], m3, r[i]);
    mst_u.frame(1'b1, m3);
    @(posedge clk_sys);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    gpioOut <= $random(seed);
    gpioOe <= $random(seed) & 32'hffffffe1;
    noise <= $random(seed);
    txb = 8'($random(seed));
    ign = 8'($random(seed));
    ovr = 8'($random(seed));
    for (int i = 0; i < 3; i++)
      b[i] = 8'($random(seed));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(spi_slave_pkg::OFS_ROUTE_SEL, 32'hffffffff);
    rd(spi_slave_pkg::OFS_SEM, 32'h1);
    rd(12'hffc, 32'h0);
    chk(padOe, gpioOe);
    chk(padOut, gpioOut);
    // routes only change while the slave is off
    wr(spi_slave_pkg::OFS_ROUTE_CLK, 32'h1);
    wr(spi_slave_pkg::OFS_ROUTE_OUT, 32'h2);
    wr(spi_slave_pkg::OFS_ROUTE_IN, 32'h3);
    wr(spi_slave_pkg::OFS_ROUTE_SEL, 32'h4);
    wr(spi_slave_pkg::OFS_RX_LIMIT, 32'h2);
    wr(spi_slave_pkg::OFS_TX_LIMIT, 32'h1);
    wr(spi_slave_pkg::OFS_IGN_CHAR, 32'(ign));
    wr(spi_slave_pkg::OFS_OVR_CHAR, 32'(ovr));
    wr(spi_slave_pkg::OFS_TX_WIN, 32'(txb));
    wr(spi_slave_pkg::OFS_ONOFF, 32'h2);
    wr(spi_slave_pkg::OFS_GIVE, 32'h1);
    rd(spi_slave_pkg::OFS_SEM, 32'h0);
    chk(32'(padOe[2]), 32'h0);
    $display("registers test done");
    // three bytes against limits of two and one
    shot(3, 1'b0);
    chk(32'(r[0]), 32'(txb));
    chk(32'(r[2]), 32'(ovr));
    rd(spi_slave_pkg::OFS_RX_LAST, 32'h2);
    rd(spi_slave_pkg::OFS_TX_LAST, 32'h1);
    rd(spi_slave_pkg::OFS_EV_RXFULL, 32'h1);
    rd(spi_slave_pkg::OFS_EV_DONE, 32'h1);
    rd(spi_slave_pkg::OFS_SEM, 32'h0);
    rd(spi_slave_pkg::OFS_RX_WIN, 32'(b[0]));
    rd(spi_slave_pkg::OFS_RX_WIN + 12'h4, 32'(b[1]));
    $display("granted test done");
    wr(spi_slave_pkg::OFS_EV_DONE, 32'h0);
    wr(spi_slave_pkg::OFS_TAKE, 32'h1);
    rd(spi_slave_pkg::OFS_SEM, 32'h1);
    shot(1, 1'b0);
    chk(32'(r[0]), 32'(ign));
    rd(spi_slave_pkg::OFS_EV_DONE, 32'h0);
    $display("ignored test done");
    wr(spi_slave_pkg::OFS_SUB_GIVE, 32'h80000003);
    chanIn <= 16'h0008;
    @(posedge clk_sys);
    chanIn <= 16'h0000;
    rd(spi_slave_pkg::OFS_SEM, 32'h0);
    // mode 3, done published on channel 5 and handed straight back to the cpu
    b[0] = 8'($random(seed));
    wr(spi_slave_pkg::OFS_FORMAT, 32'h6);
    wr(spi_slave_pkg::OFS_PUB_DONE, 32'h80000005);
    wr(spi_slave_pkg::OFS_LINKS, 32'h1);
    shot(1, 1'b1);
    chk(32'(r[0]), 32'(txb));
    rd(spi_slave_pkg::OFS_RX_WIN, 32'(b[0]));
    rd(spi_slave_pkg::OFS_RX_LAST, 32'h1);
    rd(spi_slave_pkg::OFS_SEM, 32'h1);
    chk(32'(chanSeen), 32'h20);
    wr(spi_slave_pkg::OFS_EV_GRANT, 32'h0);
    wr(spi_slave_pkg::OFS_TAKE, 32'h1);
    rd(spi_slave_pkg::OFS_EV_GRANT, 32'h1);
    $display("mode 3 and link test done");
    wr(spi_slave_pkg::OFS_ONOFF, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(padOe, gpioOe);
    $display("hook and disable test done");
    close_out;
  end
  initial
  begin
    #400000;
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
